// [tsq_pkg.sv]
// Constants, states and carriers for the TAP scan sequencer
package tsq_pkg;

	// ----------------------------------------------------------------
	// Register widths and fixed values
	// ----------------------------------------------------------------
	localparam int unsigned TSQ_IR_W = 8;
	localparam int unsigned TSQ_DR_W = 8;
	localparam logic [TSQ_IR_W-1:0] TSQ_IR_CAPTURE = 8'h81;
	localparam logic [TSQ_IR_W-1:0] TSQ_INSTR_BYPASS = 8'hff;
	localparam logic TSQ_BYPASS_CAPTURE = 1'b0;
	localparam logic [TSQ_DR_W-1:0] TSQ_DR_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Port controller states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TSQ_RESET,
		TSQ_IDLE,
		TSQ_SEL_DR,
		TSQ_CAP_DR,
		TSQ_SHIFT_DR,
		TSQ_EXIT1_DR,
		TSQ_PAUSE_DR,
		TSQ_EXIT2_DR,
		TSQ_UPD_DR,
		TSQ_SEL_IR,
		TSQ_CAP_IR,
		TSQ_SHIFT_IR,
		TSQ_EXIT1_IR,
		TSQ_PAUSE_IR,
		TSQ_EXIT2_IR,
		TSQ_UPD_IR
	} tsq_state_t;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic tms;
		logic tdi;
	} tsq_link_in_t;

	typedef struct packed {
		logic tdo;
		logic tdo_oe;
	} tsq_link_out_t;

	typedef struct packed {
		logic [TSQ_IR_W-1:0] instr;
		logic [TSQ_DR_W-1:0] data;
		logic bypass;
	} tsq_user_t;

endpackage

// [tsq_scan.sv]
// Boundary-scan port sequencer: IR, bypass and user data register scans
//
// Functional notes
// - In Shift-IR one bit moves through the 8-bit IR per TCK rise.
// - All-ones instruction decodes as bypass.
// - IR scan shifts out the captured value, LSB first.
// - Last bit shifts on the rise from Shift-IR to Exit1-IR.
// - TDO goes high-impedance on the fall after entering Exit1.
// - Update-IR moves shifted instruction to active latch on TCK fall.
// - Bypass register loads zero on the rise leaving Capture-DR.
// - TDO enabled on fall entering Shift-DR; first bit on next rise.
// - Bypass path is a one-stage delay preceded by captured zero.
// - Update-DR moves shifted data to output stage on TCK fall, unless bypass is selected.
// - Sample TDI and TMS on rises, change TDO on falls.
`timescale 1ns/1ps
`default_nettype none

module tsq_scan #(
	parameter int unsigned DR_W = tsq_pkg::TSQ_DR_W
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic TCK,
	input wire tsq_pkg::tsq_link_in_t LINK_IN,
	output tsq_pkg::tsq_link_out_t LINK_OUT,
	output tsq_pkg::tsq_user_t USER_OUT,
	output logic UPDATE
);
	import tsq_pkg::*;

	// ----------------------------------------------------------------
	// Reset into the link domain
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n_q;

	// Two stages; only the second is read
	always_ff @(posedge TCK) begin
		rst_meta_q <= NRST;
		rst_n_q <= rst_meta_q;
	end

	// ----------------------------------------------------------------
	// Controller
	// ----------------------------------------------------------------
	tsq_state_t state_q;
	tsq_state_t state_d;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			TSQ_RESET: state_d = LINK_IN.tms ? TSQ_RESET : TSQ_IDLE;
			TSQ_IDLE: state_d = LINK_IN.tms ? TSQ_SEL_DR : TSQ_IDLE;
			TSQ_SEL_DR: state_d = LINK_IN.tms ? TSQ_SEL_IR : TSQ_CAP_DR;
			TSQ_CAP_DR: state_d = LINK_IN.tms ? TSQ_EXIT1_DR : TSQ_SHIFT_DR;
			TSQ_SHIFT_DR: state_d = LINK_IN.tms ? TSQ_EXIT1_DR : TSQ_SHIFT_DR;
			TSQ_EXIT1_DR: state_d = LINK_IN.tms ? TSQ_UPD_DR : TSQ_PAUSE_DR;
			TSQ_PAUSE_DR: state_d = LINK_IN.tms ? TSQ_EXIT2_DR : TSQ_PAUSE_DR;
			TSQ_EXIT2_DR: state_d = LINK_IN.tms ? TSQ_UPD_DR : TSQ_SHIFT_DR;
			TSQ_UPD_DR: state_d = LINK_IN.tms ? TSQ_SEL_DR : TSQ_IDLE;
			TSQ_SEL_IR: state_d = LINK_IN.tms ? TSQ_RESET : TSQ_CAP_IR;
			TSQ_CAP_IR: state_d = LINK_IN.tms ? TSQ_EXIT1_IR : TSQ_SHIFT_IR;
			TSQ_SHIFT_IR: state_d = LINK_IN.tms ? TSQ_EXIT1_IR : TSQ_SHIFT_IR;
			TSQ_EXIT1_IR: state_d = LINK_IN.tms ? TSQ_UPD_IR : TSQ_PAUSE_IR;
			TSQ_PAUSE_IR: state_d = LINK_IN.tms ? TSQ_EXIT2_IR : TSQ_PAUSE_IR;
			TSQ_EXIT2_IR: state_d = LINK_IN.tms ? TSQ_UPD_IR : TSQ_SHIFT_IR;
			TSQ_UPD_IR: state_d = LINK_IN.tms ? TSQ_SEL_DR : TSQ_IDLE;
		endcase
	end

	always_ff @(posedge TCK) begin
		if (!rst_n_q) begin
			state_q <= TSQ_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// Shift stages (rising edge)
	// ----------------------------------------------------------------
	logic [TSQ_IR_W-1:0] ir_sr_q;
	logic [TSQ_IR_W-1:0] ir_active_q;
	logic bypass_q;
	logic [DR_W-1:0] dr_sr_q;
	logic [DR_W-1:0] dr_out_q;
	logic sel_bypass;

	// all ones selects the bypass path
	assign sel_bypass = (ir_active_q == TSQ_INSTR_BYPASS);

	// Instruction shift stage
	always_ff @(posedge TCK) begin
		if (!rst_n_q) begin
			ir_sr_q <= TSQ_IR_CAPTURE;
		end else if (state_q == TSQ_CAP_IR) begin
			ir_sr_q <= TSQ_IR_CAPTURE;
		end else if (state_q == TSQ_SHIFT_IR) begin
			// also shifts on the exiting rise
			ir_sr_q <= {LINK_IN.tdi, ir_sr_q[TSQ_IR_W-1:1]};
		end
	end

	// Bypass stage
	always_ff @(posedge TCK) begin
		if (!rst_n_q) begin
			bypass_q <= TSQ_BYPASS_CAPTURE;
		end else if (state_q == TSQ_CAP_DR) begin
			bypass_q <= TSQ_BYPASS_CAPTURE;
		end else if (state_q == TSQ_SHIFT_DR) begin
			// first data bit on the rise after entry
			bypass_q <= LINK_IN.tdi;
		end
	end

	// User data stage; captures its own output stage for readback
	always_ff @(posedge TCK) begin
		if (!rst_n_q) begin
			dr_sr_q <= TSQ_DR_RESET;
		end else if (state_q == TSQ_CAP_DR) begin
			dr_sr_q <= dr_out_q;
		end else if (state_q == TSQ_SHIFT_DR && !sel_bypass) begin
			dr_sr_q <= {LINK_IN.tdi, dr_sr_q[DR_W-1:1]};
		end
	end

	// ----------------------------------------------------------------
	// Falling-edge stages: update latches and serial output
	// ----------------------------------------------------------------
	logic upd_tgl_q;

	// instruction latch on the fall in Update-IR
	always_ff @(negedge TCK) begin
		if (!rst_n_q || state_q == TSQ_RESET) begin
			ir_active_q <= TSQ_INSTR_BYPASS;
		end else if (state_q == TSQ_UPD_IR) begin
			ir_active_q <= ir_sr_q;
		end
	end

	// data output stage on the fall in Update-DR
	always_ff @(negedge TCK) begin
		if (!rst_n_q) begin
			dr_out_q <= TSQ_DR_RESET;
		end else if (state_q == TSQ_UPD_DR && !sel_bypass) begin
			dr_out_q <= dr_sr_q;
		end
	end

	// Update event toggle; latched words stay put between updates, except the instruction, which returns to bypass in Reset
	always_ff @(negedge TCK) begin
		if (!rst_n_q) begin
			upd_tgl_q <= 1'b0;
		end else if (state_q == TSQ_UPD_IR || state_q == TSQ_UPD_DR) begin
			upd_tgl_q <= ~upd_tgl_q;
		end
	end

	always_ff @(negedge TCK) begin
		if (!rst_n_q) begin
			LINK_OUT <= '0;
		end else if (state_q == TSQ_SHIFT_IR) begin
			LINK_OUT.tdo <= ir_sr_q[0];
			LINK_OUT.tdo_oe <= 1'b1;
		end else if (state_q == TSQ_SHIFT_DR) begin
			// driver on at the fall entering Shift-DR
			LINK_OUT.tdo <= sel_bypass ? bypass_q : dr_sr_q[0];
			LINK_OUT.tdo_oe <= 1'b1;
		end else begin
			// released at the fall in Exit1 and elsewhere
			LINK_OUT.tdo <= 1'b0;
			LINK_OUT.tdo_oe <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Crossing to the system clock
	// ----------------------------------------------------------------
	logic tgl_meta_q;
	logic tgl_sync_q;
	logic tgl_seen_q;

	// Toggle synchroniser; words are sampled only after it settles
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			tgl_meta_q <= 1'b0;
			tgl_sync_q <= 1'b0;
			tgl_seen_q <= 1'b0;
		end else begin
			tgl_meta_q <= upd_tgl_q;
			tgl_sync_q <= tgl_meta_q;
			tgl_seen_q <= tgl_sync_q;
		end
	end

	// Registered user view; back-to-back updates need a few TCKs apart
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			USER_OUT.instr <= TSQ_INSTR_BYPASS;
			USER_OUT.data <= TSQ_DR_RESET;
			USER_OUT.bypass <= 1'b1;
			UPDATE <= 1'b0;
		end else begin
			UPDATE <= tgl_sync_q ^ tgl_seen_q;
			if (tgl_sync_q ^ tgl_seen_q) begin
				USER_OUT.instr <= ir_active_q;
				USER_OUT.data <= dr_out_q;
				USER_OUT.bypass <= sel_bypass;
			end
		end
	end

endmodule

`default_nettype wire

// [tsq_scan_sva.sv]
// Port checker for the TAP scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tsq_scan_sva #(
	parameter int unsigned DR_W = 8
) (
	input wire logic CLK,
	input wire logic NRST,
	input wire logic TCK,
	input wire tsq_pkg::tsq_link_in_t LINK_IN,
	input wire tsq_pkg::tsq_link_out_t LINK_OUT,
	input wire tsq_pkg::tsq_user_t USER_OUT,
	input wire logic UPDATE
);
	import tsq_pkg::*;
	// Short names for the link lines
	wire logic oe = LINK_OUT.tdo_oe;
	wire logic tms = LINK_IN.tms;
	// Link side, judged at falls where the outputs have settled
	property p_stay; @(negedge TCK) disable iff (!NRST) oe && !tms |=> oe; endproperty
	a_stay: assert property (p_stay) else $error("tdo dropped in shift");
	property p_exit; @(negedge TCK) disable iff (!NRST) oe && tms |=> !oe; endproperty
	a_exit: assert property (p_exit) else $error("tdo kept on exit");
	property p_en; @(negedge TCK) disable iff (!NRST) $rose(oe) |-> !$past(tms); endproperty
	a_en: assert property (p_en) else $error("tdo enabled off shift");
	property p_idle0; @(negedge TCK) disable iff (!NRST) !oe |-> !LINK_OUT.tdo; endproperty
	a_idle0: assert property (p_idle0) else $error("released tdo not low");
	// User side, then the driver after reset and covers for both sides
	property p_gap; @(posedge CLK) disable iff (!NRST) UPDATE |=> !UPDATE [*3]; endproperty
	a_gap: assert property (p_gap) else $error("update pulse too long");
	property p_hold; @(posedge CLK) disable iff (!NRST) $changed(USER_OUT) |-> UPDATE; endproperty
	a_hold: assert property (p_hold) else $error("user out moved alone");
	property p_byp;
		@(posedge CLK) disable iff (!NRST) USER_OUT.bypass == (USER_OUT.instr == TSQ_INSTR_BYPASS);
	endproperty
	a_byp: assert property (p_byp) else $error("bypass decode wrong");
	property p_rst; @(posedge CLK) disable iff (!NRST) $rose(NRST) |-> !oe [*3]; endproperty
	a_rst: assert property (p_rst) else $error("tdo on after reset");
	c_upd: cover property (@(posedge CLK) UPDATE);
	c_exit: cover property (@(negedge TCK) oe && tms);
	c_en: cover property (@(negedge TCK) $rose(oe));
endmodule
bind tsq_scan tsq_scan_sva #(.DR_W(DR_W)) u_sva (.CLK(CLK), .NRST(NRST), .TCK(TCK),
	.LINK_IN(LINK_IN), .LINK_OUT(LINK_OUT), .USER_OUT(USER_OUT), .UPDATE(UPDATE));
`default_nettype wire

// [tsq_ctrl_model.sv]
// Test controller model driving the scan link
`timescale 1ns/1ps
`default_nettype none
module tsq_ctrl_model (
	output var logic TCK,
	output var tsq_pkg::tsq_link_in_t LINK_IN,
	input wire logic TDO_LINE
);
	import tsq_pkg::*;
	// Clock stands low between frames, pins rest high
	initial begin
		TCK = 1'b0;
		LINK_IN = 2'b11;
	end
	task bit_step(input logic tms, input logic tdi, output logic seen);
		#2 LINK_IN = {tms, tdi};
		#30 TCK = 1'b1;
		seen = TDO_LINE;
		#32 TCK = 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb_tap_ir_dr_scan_sequencing.sv]
// Self-checking bench for the TAP scan sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_tap_ir_dr_scan_sequencing;
	import tsq_pkg::*;
	logic clk, nrst, tck, update, tdo_line, s;
	tsq_link_in_t link_in;
	tsq_link_out_t link_out;
	tsq_user_t user_out;
	int fails = 0;
	int samples_checked = 0;
	// Released line floats, so a stale value never matches
	assign tdo_line = link_out.tdo_oe ? link_out.tdo : 1'bz;
	tsq_scan #(.DR_W(8)) dut (.CLK(clk), .NRST(nrst), .TCK(tck), .LINK_IN(link_in),
		.LINK_OUT(link_out), .USER_OUT(user_out), .UPDATE(update));
	tsq_ctrl_model ctl (.TCK(tck), .LINK_IN(link_in), .TDO_LINE(tdo_line));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			fails++;
		end
	endtask
	task close_out();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One scan from idle or update: prefix, n bits, then update
	task shift(input logic ir, input logic [7:0] din, input int n, input logic [7:0] exp);
		int k;
		ctl.bit_step(1'b0, 1'b1, s);
		ctl.bit_step(1'b1, 1'b1, s);
		if (ir)
			ctl.bit_step(1'b1, 1'b1, s);
		ctl.bit_step(1'b0, 1'b1, s);
		ctl.bit_step(1'b0, 1'b1, s);
		for (int i = 0; i < n; i++) begin
			ctl.bit_step(i == n - 1, din[i], s);
			chk("tdo bit", {7'h0, exp[i]}, {7'h0, s});
		end
		ctl.bit_step(1'b1, 1'b1, s);
		chk("tdo enable", 8'h0, {7'h0, link_out.tdo_oe});
		k = 0;
		while (update !== 1'b1 && k < 20) begin
			@(posedge clk);
			#1 k++;
		end
		chk("update", 8'h1, {7'h0, update});
		// A wait that ran out goes straight to the verdict
		if (update !== 1'b1)
			close_out();
	endtask
	task t_ir_user();
		shift(1'b1, 8'h00, 8, 8'h81);
		chk("instr", 8'h00, user_out.instr);
		$display("test ir_user done");
	endtask
	task t_dr_user();
		shift(1'b0, 8'ha5, 8, 8'h00);
		chk("data", 8'ha5, user_out.data);
		$display("test dr_user done");
	endtask
	task t_bypass();
		shift(1'b1, 8'hff, 8, 8'h81);
		chk("bypass", 8'h1, {7'h0, user_out.bypass});
		shift(1'b0, 8'h05, 3, 8'h02);
		chk("data kept", 8'ha5, user_out.data);
		$display("test bypass done");
	endtask
	task t_reset_path();
		shift(1'b1, 8'h00, 8, 8'h81);
		shift(1'b0, 8'h00, 8, 8'ha5);
		repeat (3) ctl.bit_step(1'b1, 1'b1, s);
		shift(1'b0, 8'h01, 1, 8'h00);
		chk("bypass", 8'h1, {7'h0, user_out.bypass});
		$display("test reset_path done");
	endtask
	initial begin
		nrst = 1'b0;
		repeat (4) ctl.bit_step(1'b1, 1'b1, s);
		@(posedge clk);
		#1 nrst = 1'b1;
		repeat (5) ctl.bit_step(1'b1, 1'b1, s);
		chk("tdo enable", 8'h0, {7'h0, link_out.tdo_oe});
		t_ir_user();
		t_dr_user();
		t_bypass();
		t_reset_path();
		close_out();
	end
endmodule
`default_nettype wire
